// >>> core/tthp_pkg.sv
// Shared constants for the tone transceiver host port.
package tthp_pkg;

    // ========================================================================
    // Access codes formed as {register select line, read/write line}.
    localparam logic [1:0] ACC_WR_TX   = 2'h0;
    localparam logic [1:0] ACC_RD_RX   = 2'h1;
    localparam logic [1:0] ACC_WR_CTRL = 2'h2;
    localparam logic [1:0] ACC_RD_STAT = 2'h3;

    // ========================================================================
    // Primary control field positions.
    localparam int TONE_OUT_BIT  = 0;
    localparam int PROG_MODE_BIT = 1;
    localparam int IRQ_EN_BIT    = 2;
    localparam int REDIRECT_BIT  = 3;

    // Secondary control field positions.
    localparam int BURST_OFF_BIT = 0;
    localparam int TEST_BIT      = 1;
    localparam int SINGLE_BIT    = 2;
    localparam int COLUMN_BIT    = 3;

    // Status field positions.
    localparam int ST_IRQ_BIT    = 0;
    localparam int ST_TXRDY_BIT  = 1;
    localparam int ST_RXFULL_BIT = 2;
    localparam int ST_ABSENT_BIT = 3;

    // Reset values.
    localparam logic [3:0] CTRL_RESET   = 4'h0;
    localparam logic [3:0] RDATA_RESET  = 4'h0;
    localparam logic       ABSENT_RESET = 1'b1;

    // Host initialisation writes: set redirect, clear secondary, clear primary.
    localparam logic [3:0] INIT_REDIRECT = 4'h8;
    localparam logic [3:0] INIT_CLEAR    = 4'h0;
    localparam logic [1:0] INIT_STEPS    = 2'h3;

    // ========================================================================
    // Burst and pause timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int BURST_MS      = 51;
    localparam int BURST_CYC     = (BURST_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CNT_W         = 25;

    // Packs the two select lines into one access code.
    function automatic logic [1:0] accessCode(input logic regSel, input logic readNotWrite);
        accessCode = {regSel, readNotWrite};
    endfunction : accessCode

endpackage : tthp_pkg

// >>> core/tthp_if.sv
// Register port and interrupt pin joining the host and the transceiver.
`timescale 1ns/100ps
interface tthp_if;
    logic       registerSelectLine;
    logic       readNotWrite;
    logic       strobe;
    logic [3:0] wrData;
    logic [3:0] rdData;
    logic       irqPinOut;
    logic       irqPinOe_n;
    logic       irqPinLevel;

    // Open-drain wire with its pull-up: low only while the device drives it.
    assign irqPinLevel = irqPinOe_n ? 1'b1 : irqPinOut;

    modport dev (
        input  registerSelectLine,
        input  readNotWrite,
        input  strobe,
        input  wrData,
        output rdData,
        output irqPinOut,
        output irqPinOe_n
    );

    modport host (
        output registerSelectLine,
        output readNotWrite,
        output strobe,
        output wrData,
        input  rdData,
        input  irqPinLevel
    );
endinterface : tthp_if

// >>> core/tthp_device.sv
// Transceiver end of the host port: control, burst timing, status and pin.
//
// Summary of operation
// R01 - Secondary bit0 low: burst then equal pause.
// R02 - After pause: transmitter ready, interrupt if enabled.
// R03 - Burst and pause 51 ms, doubled in progress.
// R04 - Secondary bit0 high: tone follows output enable.
// R05 - Test bit: pin shows inverted delayed steering.
// R06 - Host selects tone mode before using test.
// R07 - Secondary bit2 picks dual or single tone.
// R08 - Secondary bit3 picks row or column tone.
// R09 - Receive register holds last valid decoded code.
// R10 - Transmit write selects generated tone pair.
// R11 - Redirect bit sends only next write secondary.
// R12 - Both control registers cleared at power-up.
// R13 - Host init writes zero to both controls.
// R14 - Select and read/write lines decode four accesses.
// R15 - Pin interrupts on tone or transmitter ready.
// R16 - Pin is open-drain, system supplies pull-up.
// R17 - Status bit0 follows bits 1/2, read-clears.
// R18 - Status bit1 on pause end, read clears.
// R19 - Status bit2 on valid receive, read clears.
// R20 - Status bit3 marks tone absent, clears on tone.
// R21 - Primary bit0 enables the tone output.
// R22 - Interrupt enable pulls pin on those events.
// R23 - Progress mode routes tones, suspends decoding.
// R24 - Status read returns old flags, then clears.
`timescale 1ns/100ps
module tthp_device #(
    parameter int unsigned BURST_CYC = tthp_pkg::BURST_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    tthp_if.dev             bus,
    input  wire logic [3:0] rxCode,
    input  wire logic       rxValid,
    input  wire logic       steerDelayed,
    input  wire logic       progressTone,
    output logic      [3:0] txCode,
    output logic            toneOn,
    output logic            singleTone,
    output logic            columnSel,
    output logic            progressMode
);

    // ========================================================================
    // Declarations.
    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_TONE,
        BURST_PAUSE
    } tthp_burst_e;

    tthp_burst_e                   burstState_q;
    logic [3:0]                    ctrlPrimary_q;
    logic [3:0]                    ctrlSecondary_q;
    logic [3:0]                    txCode_q;
    logic [3:0]                    rxCode_q;
    logic [3:0]                    rdData_q;
    logic [tthp_pkg::CNT_W-1:0]    burstCnt_q;
    logic                          redirectPend_q;
    logic                          irqFlag_q;
    logic                          txReady_q;
    logic                          rxFull_q;
    logic                          absent_q;
    logic                          toneOn_q;
    logic                          irqPinOe_n_q;
    logic                          ptMeta_q;
    logic                          ptSync_q;
    logic [1:0]                    access;
    logic                          txWrite;
    logic                          ctrlWrite;
    logic                          rxRead;
    logic                          statusRead;
    logic                          burstMode;
    logic                          pauseEnd;
    logic                          rxAccept;
    logic                          pinPull;
    logic [3:0]                    statusWord;

    // Last count of a phase, one less than its length in cycles; the length doubles while progress mode is selected.
    function automatic logic [tthp_pkg::CNT_W-1:0] phaseLast(input logic doubled);
        logic [31:0] len;
        len = doubled ? BURST_CYC * 2 : BURST_CYC;
        phaseLast = len[tthp_pkg::CNT_W-1:0] - 1'b1;
    endfunction : phaseLast
    // ========================================================================
    // Access decode from the select and read/write lines.
    assign access     = tthp_pkg::accessCode(bus.registerSelectLine, bus.readNotWrite);
    assign txWrite    = bus.strobe && (access == tthp_pkg::ACC_WR_TX);    // R14
    assign rxRead     = bus.strobe && (access == tthp_pkg::ACC_RD_RX);    // R14
    assign ctrlWrite  = bus.strobe && (access == tthp_pkg::ACC_WR_CTRL);  // R14
    assign statusRead = bus.strobe && (access == tthp_pkg::ACC_RD_STAT);  // R14

    assign burstMode  = !ctrlSecondary_q[tthp_pkg::BURST_OFF_BIT];       // R01
    assign pauseEnd   = burstMode && (burstState_q == BURST_PAUSE) && (burstCnt_q == '0);
    // Decoding is suspended while the call progress filter is selected.
    assign rxAccept   = rxValid && !ctrlPrimary_q[tthp_pkg::PROG_MODE_BIT]; // R23
    assign statusWord = {absent_q, rxFull_q, txReady_q, irqFlag_q};
    // ========================================================================
    // Progress tone comes from an analog comparator, so it is synchronised.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptMeta_q <= 1'b0;
            ptSync_q <= 1'b0;
        end else begin
            ptMeta_q <= progressTone;
            ptSync_q <= ptMeta_q;
        end
    end
    // ========================================================================
    // Control registers sharing one address; redirect steers one write only.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlPrimary_q   <= tthp_pkg::CTRL_RESET;  // R12
            ctrlSecondary_q <= tthp_pkg::CTRL_RESET;  // R12
            redirectPend_q  <= 1'b0;
        end else if (ctrlWrite) begin
            if (redirectPend_q) begin
                ctrlSecondary_q <= bus.wrData;        // R11
                redirectPend_q  <= 1'b0;              // R11
            end else begin
                ctrlPrimary_q  <= bus.wrData;
                redirectPend_q <= bus.wrData[tthp_pkg::REDIRECT_BIT];  // R11
            end
        end
    end
    // Transmit code register; the written value selects the tone pair.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txCode_q <= tthp_pkg::RDATA_RESET;
        end else if (txWrite) begin
            txCode_q <= bus.wrData;  // R10
        end
    end
    // Receive code register keeps the last accepted tone pair.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCode_q <= tthp_pkg::RDATA_RESET;
        end else if (rxAccept) begin
            rxCode_q <= rxCode;  // R09
        end
    end
    // ========================================================================
    // Burst timer: a transmit write starts a tone phase then an equal pause.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            burstState_q <= BURST_IDLE;
            burstCnt_q   <= '0;
        end else if (!burstMode) begin
            burstState_q <= BURST_IDLE;  // R04
            burstCnt_q   <= '0;
        end else if (txWrite) begin
            burstState_q <= BURST_TONE;  // R01
            burstCnt_q   <= phaseLast(ctrlPrimary_q[tthp_pkg::PROG_MODE_BIT]);  // R03
        end else begin
            case (burstState_q)
                BURST_TONE: begin
                    if (burstCnt_q == '0) begin
                        burstState_q <= BURST_PAUSE;  // R01
                        burstCnt_q   <= phaseLast(ctrlPrimary_q[tthp_pkg::PROG_MODE_BIT]); // R03
                    end else begin
                        burstCnt_q <= burstCnt_q - 1'b1;
                    end
                end
                BURST_PAUSE: begin
                    if (burstCnt_q == '0) begin
                        burstState_q <= BURST_IDLE;
                    end else begin
                        burstCnt_q <= burstCnt_q - 1'b1;
                    end
                end
                default: begin
                    burstState_q <= BURST_IDLE;
                end
            endcase
        end
    end
    // Tone output gate: enable bit, and in burst mode only the tone phase.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            toneOn_q <= 1'b0;
        end else begin
            toneOn_q <= ctrlPrimary_q[tthp_pkg::TONE_OUT_BIT]                    // R21
                        && (!burstMode || (burstState_q == BURST_TONE));           // R04
        end
    end

    // ========================================================================
    // Status flags; a set in the cycle of a status read wins over its clear.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txReady_q <= 1'b0;
        end else if (pauseEnd) begin
            txReady_q <= 1'b1;  // R02 R18
        end else if (statusRead || !burstMode) begin
            txReady_q <= 1'b0;  // R18 R24
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxFull_q <= 1'b0;
        end else if (rxAccept) begin
            rxFull_q <= 1'b1;  // R19
        end else if (statusRead) begin
            rxFull_q <= 1'b0;  // R19 R24
        end
    end
    // Summary flag set by either event source, cleared by a status read.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqFlag_q <= 1'b0;
        end else if (pauseEnd || rxAccept) begin
            irqFlag_q <= 1'b1;  // R17
        end else if (statusRead) begin
            irqFlag_q <= 1'b0;  // R17 R24
        end
    end
    // Tone-absent flag follows the inverted delayed steering level.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            absent_q <= tthp_pkg::ABSENT_RESET;
        end else begin
            absent_q <= !steerDelayed;  // R20
        end
    end
    // ========================================================================
    // Read data is captured on the read strobe, before flags clear.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= tthp_pkg::RDATA_RESET;
        end else if (statusRead) begin
            rdData_q <= statusWord;  // R24
        end else if (rxRead) begin
            rdData_q <= rxCode_q;    // R09
        end
    end
    // ========================================================================
    // Pin source: test view, progress tone, or the interrupt request.
    always_comb begin
        if (ctrlSecondary_q[tthp_pkg::TEST_BIT]) begin
            pinPull = steerDelayed;  // R05
        end else if (ctrlPrimary_q[tthp_pkg::PROG_MODE_BIT]) begin
            pinPull = ctrlPrimary_q[tthp_pkg::IRQ_EN_BIT] && !ptSync_q;  // R23
        end else begin
            pinPull = ctrlPrimary_q[tthp_pkg::IRQ_EN_BIT] && irqFlag_q;  // R15 R22
        end
    end
    // Open-drain drive: the pin is only ever pulled low.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqPinOe_n_q <= 1'b1;
        end else begin
            irqPinOe_n_q <= !pinPull;  // R16
        end
    end
    // ========================================================================
    // Outputs, each straight from a flip-flop apart from the pin data, which is tied low.
    assign bus.rdData     = rdData_q;
    assign bus.irqPinOut  = 1'b0;  // R16
    assign bus.irqPinOe_n = irqPinOe_n_q;
    assign txCode         = txCode_q;
    assign toneOn         = toneOn_q;
    assign singleTone     = ctrlSecondary_q[tthp_pkg::SINGLE_BIT];  // R07
    assign columnSel      = ctrlSecondary_q[tthp_pkg::COLUMN_BIT];  // R08
    assign progressMode   = ctrlPrimary_q[tthp_pkg::PROG_MODE_BIT];

endmodule : tthp_device

// >>> core/tthp_host.sv
// Host end of the port: initialisation, command strobes and responses.
`timescale 1ns/100ps
module tthp_host (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    tthp_if.host            bus,
    input  wire logic       cmdValid,
    output logic            cmdReady,
    input  wire logic       cmdSel,
    input  wire logic       cmdRead,
    input  wire logic [3:0] cmdData,
    output logic            rspValid,
    output logic      [3:0] rspData,
    output logic            irqActive,
    output logic            initDone
);

    // ========================================================================
    // Declarations.
    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_STROBE,
        HOST_CAPTURE
    } tthp_host_e;

    tthp_host_e  state_q;
    logic [1:0]  initStep_q;
    logic        regSel_q;
    logic        rnw_q;
    logic        strobe_q;
    logic [3:0]  wrData_q;
    logic        cmdReady_q;
    logic        rspValid_q;
    logic [3:0]  rspData_q;
    logic        irqActive_q;
    logic        redirectPend_q;
    logic        progShadow_q;
    logic        initDone_q;
    logic        initBusy;
    logic        issue;
    logic        issueSel;
    logic        issueRead;
    logic [3:0]  issueData;
    logic [3:0]  sentData;

    // ========================================================================
    // Next access: the clearing sequence first, then user commands.
    assign initBusy = (initStep_q != tthp_pkg::INIT_STEPS);
    always_comb begin
        if (initBusy) begin
            issueSel  = 1'b1;
            issueRead = 1'b0;
            issueData = (initStep_q == 2'h0) ? tthp_pkg::INIT_REDIRECT
                                             : tthp_pkg::INIT_CLEAR;  // R13
        end else begin
            issueSel  = cmdSel;
            issueRead = cmdRead;
            issueData = cmdData;
        end
    end
    assign issue = (state_q == HOST_IDLE) && (initBusy || (cmdValid && cmdReady_q));

    // A secondary write never sets test while progress mode is shadowed on.
    always_comb begin
        sentData = issueData;
        if (redirectPend_q && progShadow_q) begin
            sentData[tthp_pkg::TEST_BIT] = 1'b0;  // R06
        end
    end

    // ========================================================================
    // Sequencer: one strobe cycle, one capture cycle, then idle again.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= HOST_IDLE;
            initStep_q <= 2'h0;
            strobe_q   <= 1'b0;
            regSel_q   <= 1'b0;
            rnw_q      <= 1'b0;
            wrData_q   <= tthp_pkg::RDATA_RESET;
            cmdReady_q <= 1'b0;
            rspValid_q <= 1'b0;
            rspData_q  <= tthp_pkg::RDATA_RESET;
            initDone_q <= 1'b0;
        end else begin
            rspValid_q <= 1'b0;
            case (state_q)
                HOST_IDLE: begin
                    cmdReady_q <= !initBusy;
                    if (issue) begin
                        state_q    <= HOST_STROBE;
                        strobe_q   <= 1'b1;
                        regSel_q   <= issueSel;   // R14
                        rnw_q      <= issueRead;  // R14
                        wrData_q   <= sentData;
                        cmdReady_q <= 1'b0;
                    end
                end
                HOST_STROBE: begin
                    strobe_q <= 1'b0;
                    state_q  <= HOST_CAPTURE;
                end
                default: begin
                    state_q    <= HOST_IDLE;
                    cmdReady_q <= !initBusy || (initStep_q == 2'h2);
                    if (initBusy) begin
                        initStep_q <= initStep_q + 2'h1;  // R13
                        initDone_q <= (initStep_q == 2'h2);
                    end else begin
                        rspValid_q <= 1'b1;
                        rspData_q  <= rnw_q ? bus.rdData : wrData_q;
                    end
                end
            endcase
        end
    end

    // Shadow of the device's redirect and progress bits.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            redirectPend_q <= 1'b0;
            progShadow_q   <= 1'b0;
        end else if (issue && issueSel && !issueRead) begin
            if (redirectPend_q) begin
                redirectPend_q <= 1'b0;  // R11
            end else begin
                redirectPend_q <= sentData[tthp_pkg::REDIRECT_BIT];
                progShadow_q   <= sentData[tthp_pkg::PROG_MODE_BIT];
            end
        end
    end

    // Pin level is low while the device pulls; the pull-up makes it high.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqActive_q <= 1'b0;
        end else begin
            irqActive_q <= !bus.irqPinLevel;  // R16
        end
    end

    // ========================================================================
    // Outputs.
    assign bus.registerSelectLine = regSel_q;
    assign bus.readNotWrite       = rnw_q;
    assign bus.strobe             = strobe_q;
    assign bus.wrData             = wrData_q;
    assign cmdReady               = cmdReady_q;
    assign rspValid               = rspValid_q;
    assign rspData                = rspData_q;
    assign irqActive              = irqActive_q;
    assign initDone               = initDone_q;

endmodule : tthp_host

// >>> verif/tthp_props.sv
// Interface checker for the tone transceiver host port.
`timescale 1ns/100ps
module tthp_props (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       registerSelectLine,
    input wire logic       readNotWrite,
    input wire logic       strobe,
    input wire logic [3:0] wrData,
    input wire logic [3:0] rdData,
    input wire logic       irqPinOut,
    input wire logic       irqPinOe_n
);
    // ========================================================================
    // Shadow of the control registers.
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic redir_q, prog_q, irqEn_q, test_q, burstOff_q;
    wire  ctlWr  = strobe && registerSelectLine && !readNotWrite;
    wire  statRd = strobe && registerSelectLine && readNotWrite;

    // Follows each control write to whichever register the redirect bit picks.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {redir_q, prog_q, irqEn_q, test_q, burstOff_q} <= 5'h00;
        end else if (ctlWr && redir_q) begin
            redir_q <= 1'b0;
            test_q <= wrData[1];
            burstOff_q <= wrData[0];
        end else if (ctlWr) begin
            redir_q <= wrData[3];
            irqEn_q <= wrData[2];
            prog_q <= wrData[1];
        end
    end

    // The three start-up writes: redirect, clear secondary, clear primary.
    sequence ctrl_wr(logic [3:0] v);
        ctlWr && wrData == v;
    endsequence
    sequence init_writes;
        ctrl_wr(4'h8) ##3 ctrl_wr(4'h0) ##3 ctrl_wr(4'h0);
    endsequence

    init_order_a: assert property ($rose(rst_n) |-> ##[1:4] init_writes)
        else $error("start-up control writes wrong");
    drain_only_a: assert property (irqPinOut == 1'b0)
        else $error("pin driven high");
    strobe_gap_a: assert property (strobe |=> !strobe [*2])
        else $error("strobes too close");
    rd_hold_a: assert property (!(strobe && readNotWrite) |=> $stable(rdData))
        else $error("read data moved without a read");
    irq_summary_a: assert property (statRd |=> !(rdData[1] || rdData[2]) || rdData[0])
        else $error("summary flag missing");
    burst_off_a: assert property (statRd && burstOff_q && $past(burstOff_q) |=> !rdData[1])
        else $error("ready flag outside burst mode");
    test_mode_a: assert property (ctlWr && redir_q && prog_q |-> !wrData[1])
        else $error("test bit sent in progress mode");
    pin_idle_a: assert property ((!irqEn_q && !test_q) [*2] |-> irqPinOe_n)
        else $error("pin pulled while disabled");
endmodule : tthp_props

// >>> verif/tb_tone_transceiver_host_port.sv
// Self-checking bench joining host and transceiver ends of the port.
`timescale 1ns/100ps
module tb_tone_transceiver_host_port;
    // ========================================================================
    // Stimulus, design and checker.
    localparam int BL = 20;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cmdValid = 1'b0, cmdSel = 1'b0, cmdRead = 1'b0, rxValid = 1'b0;
    logic       steerDelayed = 1'b0, progressTone = 1'b1;
    logic [3:0] cmdData = 4'h0, rxCode = 4'h0, txCode, rspData, got;
    logic       cmdReady, rspValid, irqActive, initDone;
    logic       toneOn, singleTone, columnSel, progressMode;
    int         nErrors = 0, totalChecks = 0, n;
    wire  [2:0] flags = {!toneOn, rspValid, cmdReady};
    // Rows: {select, read}, data, response, transmit code, {single, column, progress, tone}.
    logic [17:0] rows [8] = '{{2'h2, 4'h8, 4'h8, 4'h0, 4'h0}, {2'h2, 4'hD, 4'hD, 4'h0, 4'hC},
        {2'h2, 4'h1, 4'h1, 4'h0, 4'hD}, {2'h2, 4'h3, 4'h3, 4'h0, 4'hF},
        {2'h2, 4'h1, 4'h1, 4'h0, 4'hD}, {2'h0, 4'h9, 4'h9, 4'h9, 4'hD},
        {2'h1, 4'h0, 4'h0, 4'h9, 4'hD}, {2'h3, 4'h0, 4'h8, 4'h9, 4'hD}};

    // Free-running clock of 10 ns.
    always #5 core_clk = ~core_clk;

    tthp_if bus_if ();
    tthp_device #(.BURST_CYC(BL)) u_tthp_device (.core_clk(core_clk), .rst_n(rst_n),
        .bus(bus_if), .rxCode(rxCode), .rxValid(rxValid), .steerDelayed(steerDelayed),
        .progressTone(progressTone), .txCode(txCode), .toneOn(toneOn),
        .singleTone(singleTone), .columnSel(columnSel), .progressMode(progressMode));
    tthp_host u_tthp_host (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdSel(cmdSel), .cmdRead(cmdRead),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
        .irqActive(irqActive), .initDone(initDone));
    tthp_props u_tthp_props (.core_clk(core_clk), .rst_n(rst_n),
        .registerSelectLine(bus_if.registerSelectLine), .readNotWrite(bus_if.readNotWrite),
        .strobe(bus_if.strobe), .wrData(bus_if.wrData), .rdData(bus_if.rdData),
        .irqPinOut(bus_if.irqPinOut), .irqPinOe_n(bus_if.irqPinOe_n));

    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error at %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the verdict and ends the run.
    task automatic closeOut();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : closeOut

    // Waits at falling edges for one flag, giving up after a bound.
    task automatic await(input int which, input int lim);
        n = 0;
        while (flags[which] !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > lim) begin
                nErrors++;
                closeOut();
            end
        end
    endtask : await

    // Issues one user command and keeps its response in got.
    task automatic cmd(input logic [1:0] sr, input logic [3:0] d);
        await(0, 40);
        {cmdSel, cmdRead} = sr;
        cmdData = d;
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
        await(1, 10);
        got = rspData;
        @(negedge core_clk);
    endtask : cmd

    // Delivers one decoded tone from the receiver.
    task automatic pulse(input logic [3:0] c);
        rxCode = c;
        rxValid = 1'b1;
        @(negedge core_clk);
        rxValid = 1'b0;
    endtask : pulse

    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        repeat (10) @(negedge core_clk);
        check(bus_if.rdData, 4'h0);
        check({3'h0, bus_if.irqPinLevel}, 4'h1);
        check({singleTone, columnSel, progressMode, toneOn}, 4'h0);
        rst_n = 1'b1;
        await(0, 30);
        check({3'h0, initDone}, 4'h1);
        for (int i = 0; i < 8; i++) begin
            cmd(rows[i][17:16], rows[i][15:12]);
            check(got, rows[i][11:8]);
            check(txCode, rows[i][7:4]);
            check({singleTone, columnSel, progressMode, toneOn}, rows[i][3:0]);
        end
        steerDelayed = 1'b1;
        pulse(4'h6);
        cmd(2'h3, 4'h0);
        check(got, 4'h5);
        cmd(2'h3, 4'h0);
        check(got, 4'h0);
        cmd(2'h2, 4'h3);
        pulse(4'hA);
        cmd(2'h1, 4'h0);
        check(got, 4'h6);
        cmd(2'h2, 4'h5);
        pulse(4'h2);
        repeat (4) @(negedge core_clk);
        check({3'h0, irqActive}, 4'h1);
        cmd(2'h3, 4'h0);
        check(got, 4'h5);
        repeat (2) @(negedge core_clk);
        check({3'h0, irqActive}, 4'h0);
        steerDelayed = 1'b0;
        cmd(2'h2, 4'h8);
        cmd(2'h2, 4'h0);
        for (int m = 0; m < 2; m++) begin
            cmd(2'h2, m ? 4'h7 : 4'h5);
            cmd(2'h0, 4'h4);
            await(2, 300);
            check({3'h0, n >= BL * (m + 1) - 3 && n <= BL * (m + 1) + 1}, 4'h1);
            repeat (BL * (m + 1) / 2) @(negedge core_clk);
            cmd(2'h3, 4'h0);
            check(got, 4'h8);
            repeat (BL * (m + 1)) @(negedge core_clk);
            check({3'h0, irqActive}, {3'h0, m == 0});
            cmd(2'h3, 4'h0);
            check(got, 4'hB);
        end
        cmd(2'h2, 4'hA);
        cmd(2'h2, 4'h3);
        steerDelayed = 1'b1;
        repeat (4) @(negedge core_clk);
        check({3'h0, irqActive}, 4'h0);
        cmd(2'h2, 4'h8);
        cmd(2'h2, 4'h3);
        repeat (4) @(negedge core_clk);
        check({3'h0, irqActive}, 4'h1);
        steerDelayed = 1'b0;
        repeat (4) @(negedge core_clk);
        check({3'h0, irqActive}, 4'h0);
        closeOut();
    end
endmodule : tb_tone_transceiver_host_port
